// *** core/encif_pkg.sv ***
// Shared constants, encodings and carrier types of the encoder interface
package encif_pkg;

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int POS_W = 12;
  localparam int FIFO_DEPTH = 4;
  localparam int PIN_W = 12;
  localparam int JMP_W = 3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int ENC_MAX_HZ = 200_000;
  localparam int FAULT_TIME_NS = 10_000;
  localparam int SER_BIT_NS = 1_000;
  localparam logic [5:0] PQ_STEP_CYC = 6'(CLK_HZ / (4 * ENC_MAX_HZ));
  localparam logic [8:0] FAULT_CYC = 9'((FAULT_TIME_NS * (CLK_HZ / 1_000_000)) / 1000);
  localparam logic [4:0] SER_HALF_CYC = 5'((SER_BIT_NS * (CLK_HZ / 1_000_000)) / 2000);
  localparam logic [3:0] SER_LAST_BIT = 4'hb;

  // ---------------------------------------------------------------
  // Pin positions (quadrature view of the 12 inputs) and jumper positions above them
  // ---------------------------------------------------------------
  localparam int PIN_A1P = 0;
  localparam int PIN_A1N = 1;
  localparam int PIN_B1P = 2;
  localparam int PIN_B1N = 3;
  localparam int PIN_Z1P = 4;
  localparam int PIN_Z1N = 5;
  localparam int PIN_CH2 = 6;
  localparam int JMP_KIND = 12;
  localparam int JMP_POL = 13;
  localparam int JMP_CODE = 14;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [14:0] RST_SYNC = 15'h7000;
  localparam logic [POS_W-1:0] RST_POS = 12'h000;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SER_IDLE = 3'h1,
    SER_LO = 3'h2,
    SER_HI = 3'h4
  } encif_ser_st_t;

  typedef enum logic [6:0] {
    MODE_SINGLE = 7'h01,
    MODE_DUAL = 7'h02,
    MODE_REDUND = 7'h04,
    MODE_GRAY_LO = 7'h08,
    MODE_BIN_LO = 7'h10,
    MODE_GRAY_HI = 7'h20,
    MODE_BIN_HI = 7'h40
  } encif_mode_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic a_p;
    logic a_n;
    logic b_p;
    logic b_n;
    logic z_p;
    logic z_n;
  } encif_quad_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic frame;
  } encif_ser_t;

endpackage

// *** core/encif_fifo.sv ***
// Small synchronous FIFO holding captured position words
module encif_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } encif_fifo_st_t;

  encif_fifo_st_t q_ff;
  encif_fifo_st_t nxt_q;
  logic push;
  logic pop;

  // ---------------------------------------------------------------
  // Pointers and storage
  // ---------------------------------------------------------------
  always_comb begin
    in_ready = (q_ff.count != CW'(DEPTH));
    out_valid = (q_ff.count != '0);
    out_data = q_ff.mem[q_ff.rd_ptr];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    nxt_q = q_ff;
    if (push) begin
      nxt_q.mem[q_ff.wr_ptr] = in_data;
      nxt_q.wr_ptr = (q_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : q_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_q.rd_ptr = (q_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : q_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_q.count = q_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_q.count = q_ff.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

// *** core/encif_top.sv ***
// Encoder interface: mode decode, failover, absolute processing, serial out
//
// Contract
// - Input-kind removed absolute, installed quadrature
// - All three installed gives single quadrature
// - Code/dual removed, polarity installed gives selectable dual encoders
// - Polarity and code removed gives redundant failover
// - Failover latched until control power reset
// - Polarity removed, code installed stays single
// - Code installed Gray, polarity installed low-true
// - Gray low-true: invert, then Gray to binary
// - Binary low-true: invert only
// - Gray high-true: convert, no inversion
// - Binary high-true: pass unchanged
// - Each processor request in absolute mode sends one serial word
// - Absolute mode synthesises pseudo quadrature and zero
// - First channel primary, second channel additional
// - Twelve single-ended inputs reuse six pairs
// - Encoder signals handled up to 200 kHz
module encif_top
  import encif_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration jumpers, high when installed
  input wire logic input_kind_select,
  input wire logic polarity_redundancy_select,
  input wire logic code_dual_select,
  // Encoder pins
  input wire logic [PIN_W-1:0] enc_pins,
  // Drive processor requests
  input wire logic pos_req,
  output logic pos_req_ready,
  input wire logic enc_second_sel,
  input wire logic primary_fault,
  // Drive processor outputs
  output encif_quad_t quad_out,
  output encif_ser_t ser_out,
  output logic failover_active,
  output logic abs_mode_active
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [14:0] sync1;
    logic [14:0] sync2;
    logic failover;
    logic [8:0] flt_cnt;
    logic [POS_W-1:0] pq_count;
    logic [5:0] step_cnt;
    encif_quad_t quad;
    logic abs_mode;
    encif_ser_st_t ser_st;
    logic [POS_W-1:0] shift;
    logic [3:0] bit_cnt;
    logic [4:0] div_cnt;
    encif_ser_t ser;
  } encif_state_t;

  encif_state_t q_ff;
  encif_state_t nxt_q;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic encif_mode_t encif_decode(input logic kind, input logic pol,
                                               input logic code);
    encif_mode_t m;
    m = MODE_SINGLE;
    case ({kind, pol, code})
      3'h7: m = MODE_SINGLE;
      3'h6: m = MODE_DUAL;
      3'h4: m = MODE_REDUND;
      3'h5: m = MODE_SINGLE;
      3'h3: m = MODE_GRAY_LO;
      3'h2: m = MODE_BIN_LO;
      3'h1: m = MODE_GRAY_HI;
      3'h0: m = MODE_BIN_HI;
      default: m = MODE_SINGLE;
    endcase
    return m;
  endfunction

  function automatic logic encif_is_abs(input encif_mode_t m);
    return (m == MODE_GRAY_LO) || (m == MODE_BIN_LO) ||
           (m == MODE_GRAY_HI) || (m == MODE_BIN_HI);
  endfunction

  function automatic logic [POS_W-1:0] encif_gray2bin(input logic [POS_W-1:0] g);
    logic [POS_W-1:0] b;
    b = '0;
    b[POS_W-1] = g[POS_W-1];
    for (int i = POS_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [POS_W-1:0] encif_condition(input logic [POS_W-1:0] raw,
                                                      input encif_mode_t m);
    logic [POS_W-1:0] v;
    v = raw;
    case (m)
      MODE_GRAY_LO: v = encif_gray2bin(~raw);
      MODE_BIN_LO: v = ~raw;
      MODE_GRAY_HI: v = encif_gray2bin(raw);
      MODE_BIN_HI: v = raw;
      default: v = raw;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------
  encif_mode_t mode;
  logic [PIN_W-1:0] pins;
  logic [POS_W-1:0] pos_bin;
  logic [POS_W-1:0] pq_diff;
  logic is_abs;
  logic prim_bad;
  logic use_second;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [POS_W-1:0] fifo_out_data;
  encif_quad_t chan;

  // ---------------------------------------------------------------
  // Capture buffer
  // ---------------------------------------------------------------
  // Four words absorb a burst of requests while one word is shifting
  // Requests beyond four pending words are held off by the ready
  encif_fifo #(
    .WIDTH(POS_W),
    .DEPTH(FIFO_DEPTH)
  ) i_encif_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(pos_bin),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;

    // Pins and jumpers cross in through two flops
    // Jumpers are meant to move only with control power off
    nxt_q.sync1 = {code_dual_select, polarity_redundancy_select,
                   input_kind_select, enc_pins};
    nxt_q.sync2 = q_ff.sync1;

    // Mode comes from synchronised jumpers only, never the raw pins
    mode = encif_decode(q_ff.sync2[JMP_KIND], q_ff.sync2[JMP_POL],
                        q_ff.sync2[JMP_CODE]);
    is_abs = encif_is_abs(mode);
    nxt_q.abs_mode = is_abs;

    pins = q_ff.sync2[PIN_W-1:0];
    pos_bin = encif_condition(pins, mode);

    fifo_in_valid = pos_req & is_abs;
    pos_req_ready = fifo_in_ready & is_abs;

    // Primary health: an A or B differential pair at equal levels is broken
    prim_bad = (pins[PIN_A1P] == pins[PIN_A1N]) ||
               (pins[PIN_B1P] == pins[PIN_B1N]);

    // switch to second on primary fault
    if (mode == MODE_REDUND) begin
      if (primary_fault) begin
        nxt_q.failover = 1'b1;
      end
      if (prim_bad) begin
        if (q_ff.flt_cnt == FAULT_CYC - 9'h001) begin
          nxt_q.failover = 1'b1;
        end else begin
          nxt_q.flt_cnt = q_ff.flt_cnt + 9'h001;
        end
      end else begin
        nxt_q.flt_cnt = 9'h000;
      end
    end else begin
      nxt_q.flt_cnt = 9'h000;
    end
    // A spurious fault pulse is latched too; safety over availability
    // failover never clears here
    if (q_ff.failover) begin
      nxt_q.failover = 1'b1;
    end

    // drive picks channel in dual mode
    use_second = ((mode == MODE_DUAL) & enc_second_sel) |
                 ((mode == MODE_REDUND) & q_ff.failover);
    if (use_second) begin
      chan = encif_quad_t'(pins[PIN_CH2 +: 6] >> 0);
    end else begin
      chan = encif_quad_t'(pins[PIN_Z1N:PIN_A1P]);
    end
    // Struct order is a_p first; reverse pin order into it
    chan = {chan.z_n, chan.z_p, chan.b_n, chan.b_p, chan.a_n, chan.a_p};

    // A large position jump ramps over at one count per step
    // 4 steps per 200 kHz period
    pq_diff = pos_bin - q_ff.pq_count;
    if (q_ff.step_cnt == PQ_STEP_CYC - 6'h01) begin
      nxt_q.step_cnt = 6'h00;
      if (pq_diff != RST_POS) begin
        // Shortest way round keeps direction right across wrap
        if (pq_diff[POS_W-1]) begin
          nxt_q.pq_count = q_ff.pq_count - 12'h001;
        end else begin
          nxt_q.pq_count = q_ff.pq_count + 12'h001;
        end
      end
    end else begin
      nxt_q.step_cnt = q_ff.step_cnt + 6'h01;
    end

    if (is_abs) begin
      nxt_q.quad.a_p = q_ff.pq_count[1];
      nxt_q.quad.a_n = ~q_ff.pq_count[1];
      nxt_q.quad.b_p = q_ff.pq_count[1] ^ q_ff.pq_count[0];
      nxt_q.quad.b_n = ~(q_ff.pq_count[1] ^ q_ff.pq_count[0]);
      nxt_q.quad.z_p = (q_ff.pq_count == RST_POS);
      nxt_q.quad.z_n = (q_ff.pq_count != RST_POS);
    end else begin
      nxt_q.quad = chan;
    end

    // shift out MSB first
    // A word is taken only while the link is idle
    fifo_out_ready = (q_ff.ser_st == SER_IDLE);
    case (q_ff.ser_st)
      SER_IDLE: begin
        nxt_q.ser.clk = 1'b0;
        if (fifo_out_valid) begin
          nxt_q.shift = fifo_out_data;
          nxt_q.ser.data = fifo_out_data[POS_W-1];
          nxt_q.ser.frame = 1'b1;
          nxt_q.bit_cnt = 4'h0;
          nxt_q.div_cnt = 5'h00;
          nxt_q.ser_st = SER_LO;
        end
      end
      SER_LO: begin
        if (q_ff.div_cnt == SER_HALF_CYC - 5'h01) begin
          nxt_q.div_cnt = 5'h00;
          nxt_q.ser.clk = 1'b1;
          nxt_q.ser_st = SER_HI;
        end else begin
          nxt_q.div_cnt = q_ff.div_cnt + 5'h01;
        end
      end
      SER_HI: begin
        if (q_ff.div_cnt == SER_HALF_CYC - 5'h01) begin
          nxt_q.div_cnt = 5'h00;
          nxt_q.ser.clk = 1'b0;
          if (q_ff.bit_cnt == SER_LAST_BIT) begin
            nxt_q.ser.frame = 1'b0;
            nxt_q.ser.data = 1'b0;
            nxt_q.ser_st = SER_IDLE;
          end else begin
            nxt_q.shift = {q_ff.shift[POS_W-2:0], 1'b0};
            nxt_q.ser.data = q_ff.shift[POS_W-2];
            nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
            nxt_q.ser_st = SER_LO;
          end
        end else begin
          nxt_q.div_cnt = q_ff.div_cnt + 5'h01;
        end
      end
      default: begin
        nxt_q.ser_st = SER_IDLE;
        nxt_q.ser = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // only reset releases failover
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff.sync1 <= RST_SYNC;
      q_ff.sync2 <= RST_SYNC;
      q_ff.failover <= 1'b0;
      q_ff.flt_cnt <= 9'h000;
      q_ff.pq_count <= RST_POS;
      q_ff.step_cnt <= 6'h00;
      q_ff.quad <= '0;
      q_ff.abs_mode <= 1'b0;
      q_ff.ser_st <= SER_IDLE;
      q_ff.shift <= RST_POS;
      q_ff.bit_cnt <= 4'h0;
      q_ff.div_cnt <= 5'h00;
      q_ff.ser <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output but pos_req_ready comes from a flop, so no glitch reaches the processor
  assign quad_out = q_ff.quad;
  assign ser_out = q_ff.ser;
  assign failover_active = q_ff.failover;
  assign abs_mode_active = q_ff.abs_mode;

endmodule

// *** bench/encif_top_chk.sv ***
// Port-level assertion checker of the encoder interface
module encif_top_chk
  import encif_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Jumpers and pins
  input wire logic input_kind_select,
  input wire logic polarity_redundancy_select,
  input wire logic code_dual_select,
  input wire logic [PIN_W-1:0] enc_pins,
  // Processor side
  input wire logic pos_req,
  input wire logic pos_req_ready,
  input wire logic enc_second_sel,
  input wire logic primary_fault,
  input wire encif_quad_t quad_out,
  input wire encif_ser_t ser_out,
  input wire logic failover_active,
  input wire logic abs_mode_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [9:0] frm_cnt_ff;
  logic red_mode;
  assign red_mode = input_kind_select && !polarity_redundancy_select && !code_dual_select;
  function automatic logic [5:0] qm(input logic [5:0] p);
    return {p[0], p[1], p[2], p[3], p[4], p[5]};
  endfunction
  // Counts frame-high cycles so a short or long word shows up at its end
  always_ff @(posedge sys_clk) begin
    if (rst || !ser_out.frame) begin
      frm_cnt_ff <= 10'h000;
    end else begin
      frm_cnt_ff <= frm_cnt_ff + 10'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_abs_mode; (!input_kind_select)[*5] |-> abs_mode_active; endproperty
  a_abs_mode: assert property (p_abs_mode) else $error("absolute mode missing");
  // Ready follows the decoded mode at once, the mode flag one clock later
  property p_ready_abs; pos_req_ready |=> abs_mode_active; endproperty
  a_ready_abs: assert property (p_ready_abs) else $error("ready outside absolute");
  property p_single;
    (input_kind_select && code_dual_select)[*6] |-> quad_out == qm($past(enc_pins[5:0], 3));
  endproperty
  a_single: assert property (p_single) else $error("single channel wrong");
  property p_dual2;
    (input_kind_select && polarity_redundancy_select && !code_dual_select && enc_second_sel)[*6]
      |-> quad_out == qm($past(enc_pins[11:6], 3));
  endproperty
  a_dual2: assert property (p_dual2) else $error("second channel wrong");
  property p_fo_latch; failover_active |=> failover_active; endproperty
  a_fo_latch: assert property (p_fo_latch) else $error("failover dropped");
  property p_fo_fault; (red_mode && primary_fault)[*6] |-> failover_active; endproperty
  a_fo_fault: assert property (p_fo_fault) else $error("fault not taken");
  property p_fo_cause; $rose(failover_active) |-> $past(red_mode, 3); endproperty
  a_fo_cause: assert property (p_fo_cause) else $error("failover out of mode");
  property p_frame_len; $fell(ser_out.frame) |-> frm_cnt_ff == 10'h1e0; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_clk_high; $rose(ser_out.clk) |-> ##19 ser_out.clk ##1 !ser_out.clk; endproperty
  a_clk_high: assert property (p_clk_high) else $error("serial clock high time");
  property p_data_hold;
    ser_out.frame && $past(ser_out.frame) && $changed(ser_out.data) |-> !ser_out.clk;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved with clock high");
  property p_answer; pos_req && pos_req_ready && !ser_out.frame |-> ##[1:3] ser_out.frame;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_compl;
    abs_mode_active[*3] |-> quad_out.a_n != quad_out.a_p && quad_out.z_n != quad_out.z_p;
  endproperty
  a_compl: assert property (p_compl) else $error("pseudo pair not complementary");
  c_frame: cover property ($rose(ser_out.frame));
  c_failover: cover property ($rose(failover_active));
  c_full: cover property (abs_mode_active && !pos_req_ready);
endmodule

bind encif_top encif_top_chk i_encif_top_chk (.sys_clk, .rst, .input_kind_select,
  .polarity_redundancy_select, .code_dual_select, .enc_pins, .pos_req, .pos_req_ready,
  .enc_second_sel, .primary_fault, .quad_out, .ser_out, .failover_active, .abs_mode_active);

// *** bench/encif_dpm_model.sv ***
// Drive processor model: requests words and deserialises the link
module encif_drive_processor_model
  import encif_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench command
  input wire logic req_go,
  // Link to the interface
  input wire logic pos_req_ready,
  output logic pos_req,
  input wire encif_ser_t ser_out,
  // Received words
  output logic [POS_W-1:0] rx_word,
  output logic rx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_ff;
  logic frm_ff;
  logic [POS_W-1:0] shf_ff;
  always_ff @(posedge sys_clk) begin
    clk_ff <= ser_out.clk;
    frm_ff <= ser_out.frame;
    rx_done <= 1'b0;
    if (rst) begin
      pos_req <= 1'b0;
    end else begin
      if (pos_req) begin
        pos_req <= !pos_req_ready;
      end else begin
        pos_req <= req_go;
      end
      if (ser_out.frame && ser_out.clk && !clk_ff) begin
        shf_ff <= {shf_ff[POS_W-2:0], ser_out.data};
      end
      if (frm_ff && !ser_out.frame) begin
        rx_word <= shf_ff;
        rx_done <= 1'b1;
      end
    end
  end
endmodule

// *** bench/encif_top_bench.sv ***
// Self-checking bench of the encoder interface
module encif_top_bench
  import encif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic kind = 1'b1;
  logic pol = 1'b1;
  logic code = 1'b1;
  logic [PIN_W-1:0] pins = 12'h000;
  logic sec = 1'b0;
  logic flt = 1'b0;
  logic go = 1'b0;
  logic req;
  logic rdy;
  encif_quad_t quad;
  encif_ser_t ser;
  logic fo;
  logic absm;
  logic [POS_W-1:0] rx_word;
  logic rx_done;
  int err_total = 0;
  int samples_checked = 0;
  encif_top i_encif_top (.sys_clk(sys_clk), .rst(rst), .input_kind_select(kind),
    .polarity_redundancy_select(pol), .code_dual_select(code), .enc_pins(pins),
    .pos_req(req), .pos_req_ready(rdy), .enc_second_sel(sec), .primary_fault(flt),
    .quad_out(quad), .ser_out(ser), .failover_active(fo), .abs_mode_active(absm));
  encif_drive_processor_model i_encif_drive_processor_model (.sys_clk(sys_clk), .rst(rst),
    .req_go(go),
    .pos_req_ready(rdy), .pos_req(req), .ser_out(ser), .rx_word(rx_word), .rx_done(rx_done));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Jumpers only matter through reset in the bench, as on the board
  task automatic setup(input logic k, input logic p, input logic c);
    rst = 1'b1;
    kind = k;
    pol = p;
    code = c;
    step(16);
    rst = 1'b0;
    step(4);
  endtask
  task automatic wait_rx;
    int n;
    n = 0;
    while (rx_done !== 1'b1) begin
      step(1);
      n++;
      if (n > 2000) begin
        err_total++;
        $display("wait for received word timed out");
        disable run_all;
      end
    end
  endtask
  function automatic logic [5:0] qm(input logic [5:0] p);
    return {p[0], p[1], p[2], p[3], p[4], p[5]};
  endfunction
  function automatic logic [11:0] g2b(input logic [11:0] g);
    logic [11:0] b;
    b[11] = g[11];
    for (int i = 10; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_abs;
    logic [11:0] p0;
    logic [11:0] v;
    for (int m = 0; m < 4; m++) begin
      p0 = 12'hc5a;
      pins = p0;
      setup(1'b0, m[1], m[0]);
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(2);
      pins = ~p0;
      wait_rx();
      v = m[1] ? ~p0 : p0;
      if (m[0]) v = g2b(v);
      chk({4'h0, rx_word}, {4'h0, v});
      chk({15'h0, absm}, 16'h0001);
      step(1);
    end
    $display("absolute decode done");
  endtask
  task automatic t_fill;
    int cnt;
    logic full;
    cnt = 0;
    full = 1'b0;
    pins = 12'h3c1;
    setup(1'b0, 1'b0, 1'b0);
    go = 1'b1;
    repeat (12) begin
      step(1);
      if (rdy === 1'b0) full = 1'b1;
    end
    go = 1'b0;
    for (int n = 0; n < 3000; n++) begin
      step(1);
      if (rx_done === 1'b1) begin
        cnt++;
        chk({4'h0, rx_word}, 16'h03c1);
      end
    end
    chk({15'h0, full}, 16'h0001);
    // The held sixth request is taken once the first drained word frees a slot
    chk(16'(cnt), 16'h0006);
    $display("fifo fill done");
  endtask
  task automatic t_quad;
    logic [4:0] cfg [4];
    cfg = '{5'b11111, 5'b10101, 5'b11001, 5'b11011};
    pins = 12'h6a5;
    for (int i = 0; i < 4; i++) begin
      sec = cfg[i][1];
      flt = cfg[i][0];
      setup(cfg[i][4], cfg[i][3], cfg[i][2]);
      step(6);
      chk({10'h0, quad}, {10'h0, (i == 3) ? qm(pins[11:6]) : qm(pins[5:0])});
      chk({15'h0, fo}, 16'h0000);
    end
    sec = 1'b0;
    flt = 1'b0;
    $display("quadrature modes done");
  endtask
  task automatic t_redund;
    pins = 12'h6a5;
    setup(1'b1, 1'b0, 1'b0);
    step(300);
    chk({15'h0, fo}, 16'h0000);
    pins = 12'h6a7;
    step(380);
    chk({15'h0, fo}, 16'h0000);
    step(40);
    chk({15'h0, fo}, 16'h0001);
    chk({10'h0, quad}, {10'h0, qm(pins[11:6])});
    pins = 12'h6a5;
    step(50);
    chk({15'h0, fo}, 16'h0001);
    setup(1'b1, 1'b0, 1'b0);
    chk({15'h0, fo}, 16'h0000);
    flt = 1'b1;
    step(8);
    flt = 1'b0;
    chk({15'h0, fo}, 16'h0001);
    $display("redundant failover done");
  endtask
  task automatic t_pseudo;
    pins = 12'h000;
    setup(1'b0, 1'b0, 1'b0);
    step(10);
    chk({10'h0, quad}, 16'h0016);
    pins = 12'h003;
    step(220);
    chk({10'h0, quad}, 16'h0025);
    $display("pseudo quadrature done");
  endtask
  initial begin
    begin : run_all
      t_abs();
      t_fill();
      t_quad();
      t_redund();
      t_pseudo();
    end
    report_and_stop();
  end
endmodule
